// *** design/ldc_pkg.sv ***
// constants and types for the per-lane dc balance coder
// Summary of operation
// - With balancing on, every lane carries one balance bit beside its data bits in every cycle.
// - The word disparity of a lane is its count of ones minus its count of zeros.
// - The running disparity may start anywhere from -6 to +7.
// - After each word the running disparity grows by d-1 if sent plain or 1-d if sent inverted.
// - The running disparity saturates at +7 and -6 and never wraps.
// - The balance bit is 0 for a plain word and 1 for an inverted word.
// - Each lane word goes out either exactly as given or with all data bits complemented.
// - Positive running and positive word disparity send the word inverted.
// - Positive running and zero or negative word disparity send the word plain.
// - Negative running and positive word disparity send the word plain.
// - Zero running disparity sends the word inverted whatever its own disparity.
// - Unbalanced mode uses the legacy lane mapping for older narrower receivers.
// - Receiver skew calibration is offered only while balanced coding is on.
package ldc_pkg;

  localparam int NUM_LANES = 8;
  localparam int LANE_BITS = 6;
  localparam int WORD_BITS = NUM_LANES * LANE_BITS;
  localparam int FIFO_DEPTH = 32;

  typedef logic signed [3:0] ldc_rd_t;
  typedef logic signed [3:0] ldc_disp_t;

  localparam ldc_rd_t RD_MAX = 4'sh7;
  localparam ldc_rd_t RD_MIN = 4'shA;
  localparam ldc_rd_t RD_INIT = 4'sh0;
  localparam ldc_disp_t DISP_ONE = 4'sh1;
  localparam ldc_disp_t DISP_OFS = 4'sh6;
  localparam logic LEGACY_PAD = 1'b0;

  typedef struct packed {
    logic flag;
    logic [LANE_BITS-1:0] data;
  } ldc_lane_t;

  typedef struct packed {
    logic [1:0] bal_sync;
    logic calib_ok;
    ldc_rd_t [NUM_LANES-1:0] rd;
    ldc_lane_t [NUM_LANES-1:0] lane;
    logic lane_valid;
  } ldc_link_state_t;

  localparam ldc_link_state_t LINK_RST = '{
    bal_sync: 2'h0,
    calib_ok: 1'b0,
    rd: {NUM_LANES{RD_INIT}},
    lane: '0,
    lane_valid: 1'b0
  };

endpackage

// *** design/ldc_fifo.sv ***
// dual clock fifo with gray pointers and a registered read port
`timescale 1ns/1ns
module ldc_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  input wire logic wr_clk_i,
  input wire logic wr_rst_n_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic rd_clk_i,
  input wire logic rd_rst_n_i,
  output logic [WIDTH-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] far1;
    logic [AW:0] far2;
  } ptr_state_t;

  typedef struct packed {
    ptr_state_t p;
    logic valid;
  } rd_state_t;

  logic [WIDTH-1:0] mem [DEPTH];
  ptr_state_t w_r, w_nxt;
  rd_state_t r_r, r_nxt;
  logic [WIDTH-1:0] rdata_r;
  logic full, empty, push, pop;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // full when the far pointer is one lap behind: top two gray bits differ
  assign full = (w_r.gray == {~w_r.far2[AW:AW-1], w_r.far2[AW-2:0]});
  assign wr_ready_o = !full;
  assign push = wr_valid_i && !full;
  assign empty = (r_r.p.gray == r_r.p.far2);
  assign pop = !empty && (!r_r.valid || rd_ready_i);
  assign rd_valid_o = r_r.valid;
  assign rd_data_o = rdata_r;

  always_comb begin
    w_nxt = w_r;
    w_nxt.far1 = r_r.p.gray;
    w_nxt.far2 = w_r.far1;
    if (push) begin
      w_nxt.bin = w_r.bin + 1'b1;
      w_nxt.gray = to_gray(w_nxt.bin);
    end
  end

  always_comb begin
    r_nxt = r_r;
    r_nxt.p.far1 = w_r.gray;
    r_nxt.p.far2 = r_r.p.far1;
    if (pop) begin
      r_nxt.p.bin = r_r.p.bin + 1'b1;
      r_nxt.p.gray = to_gray(r_nxt.p.bin);
      r_nxt.valid = 1'b1;
    end else if (rd_ready_i) begin
      r_nxt.valid = 1'b0;
    end
  end

  always_ff @(posedge wr_clk_i or negedge wr_rst_n_i) begin
    if (!wr_rst_n_i) begin
      w_r <= '0;
    end else begin
      w_r <= w_nxt;
    end
  end

  always_ff @(posedge wr_clk_i) begin
    if (push) begin
      mem[w_r.bin[AW-1:0]] <= wr_data_i;
    end
  end

  always_ff @(posedge rd_clk_i or negedge rd_rst_n_i) begin
    if (!rd_rst_n_i) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // read data register has no reset; it is only looked at while valid
  always_ff @(posedge rd_clk_i) begin
    if (pop) begin
      rdata_r <= mem[r_r.p.bin[AW-1:0]];
    end
  end
endmodule

// *** design/ldc_coder.sv ***
// transmit-side per-lane dc balance coder with clock-crossing input fifo
`timescale 1ns/1ns
module ldc_coder
  import ldc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic link_clk_i,
  input wire logic [WORD_BITS-1:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic balance_select_pin_i,
  input wire logic ser_ready_i,
  output ldc_lane_t [NUM_LANES-1:0] lane_word_o,
  output logic lane_valid_o,
  output logic calib_allowed_o
);

  logic [1:0] lrst_sync_r;
  logic lrst_n;
  logic [WORD_BITS-1:0] src_data;
  logic src_valid;
  logic fire;
  logic balance_select_pin;
  ldc_link_state_t s_r, s_nxt;

  ldc_disp_t disp_w [NUM_LANES];
  logic inv_w [NUM_LANES];
  ldc_disp_t adj_w [NUM_LANES];
  ldc_rd_t rdn_w [NUM_LANES];

  // ones minus zeros of one lane word; 4-bit wrap is harmless, result is -6..+6
  function automatic ldc_disp_t word_disp(input logic [LANE_BITS-1:0] w);
    logic [2:0] ones;
    ones = 3'h0;
    for (int i = 0; i < LANE_BITS; i++) begin
      ones = ones + 3'(w[i]);
    end
    return ldc_disp_t'({ones, 1'b0}) - DISP_OFS;
  endfunction

  function automatic logic choose_invert(input ldc_rd_t rd, input ldc_disp_t d);
    logic rd_pos, d_pos;
    rd_pos = (rd > RD_INIT);
    d_pos = (d > 4'sh0);
    if (rd == RD_INIT) begin
      return 1'b1;
    end
    // same sign sends inverted, opposite sign sends plain
    return (rd_pos == d_pos);
  endfunction

  function automatic ldc_rd_t rd_next(input ldc_rd_t rd, input ldc_disp_t adj);
    logic signed [4:0] sum;
    sum = 5'(rd) + 5'(adj);
    if (sum > 5'(RD_MAX)) begin
      return RD_MAX;
    end
    if (sum < 5'(RD_MIN)) begin
      return RD_MIN;
    end
    return ldc_rd_t'(sum);
  endfunction

  // link-side reset: asserts at once, releases on the link clock
  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lrst_sync_r <= 2'h0;
    end else begin
      lrst_sync_r <= {lrst_sync_r[0], 1'b1};
    end
  end
  assign lrst_n = lrst_sync_r[1];

  // the fifo is the crossing from the system clock to the link clock
  ldc_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .wr_clk_i(sys_clk_i),
    .wr_rst_n_i(arst_n_i),
    .wr_data_i(tx_data_i),
    .wr_valid_i(tx_valid_i),
    .wr_ready_o(tx_ready_o),
    .rd_clk_i(link_clk_i),
    .rd_rst_n_i(lrst_n),
    .rd_data_o(src_data),
    .rd_valid_o(src_valid),
    .rd_ready_i(ser_ready_i)
  );

  assign fire = src_valid && ser_ready_i;
  assign balance_select_pin = s_r.bal_sync[1];

  generate
    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
      assign disp_w[g] = word_disp(src_data[g*LANE_BITS +: LANE_BITS]);
      assign inv_w[g] = choose_invert(s_r.rd[g], disp_w[g]);
      assign adj_w[g] = inv_w[g] ? (DISP_ONE - disp_w[g]) : (disp_w[g] - DISP_ONE);
      assign rdn_w[g] = rd_next(s_r.rd[g], adj_w[g]);
    end
  endgenerate

  always_comb begin
    s_nxt = s_r;
    s_nxt.bal_sync = {s_r.bal_sync[0], balance_select_pin_i};
    s_nxt.calib_ok = balance_select_pin;
    s_nxt.lane_valid = fire;
    if (fire) begin
      for (int i = 0; i < NUM_LANES; i++) begin
        if (balance_select_pin) begin
          s_nxt.lane[i].flag = inv_w[i];
          // whole word flipped or untouched, never partly
          s_nxt.lane[i].data = inv_w[i] ? ~src_data[i*LANE_BITS +: LANE_BITS]
                                        : src_data[i*LANE_BITS +: LANE_BITS];
          s_nxt.rd[i] = rdn_w[i];
        end else begin
          // legacy mapping: pad slot fixed, disparity left untouched
          s_nxt.lane[i].flag = LEGACY_PAD;
          s_nxt.lane[i].data = src_data[i*LANE_BITS +: LANE_BITS];
        end
      end
    end
  end

  // running disparity resets to zero, inside the allowed start range
  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      s_r <= LINK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lane_word_o = s_r.lane;
  assign lane_valid_o = s_r.lane_valid;
  assign calib_allowed_o = s_r.calib_ok;

  default clocking cb @(posedge link_clk_i);
  endclocking
  default disable iff (!lrst_n);

  a_calib_follows: assert property (
    $changed(balance_select_pin) |=> (calib_allowed_o == $past(balance_select_pin)))
    else $error("calibration permission does not follow balance mode");

  a_valid_follows: assert property (
    fire |=> lane_valid_o)
    else $error("lane valid did not follow a taken word");

  a_idle_no_valid: assert property (
    !fire |=> !lane_valid_o)
    else $error("lane valid without a taken word");

  generate
    for (genvar g = 0; g < NUM_LANES; g++) begin : g_chk
      sequence s_take_bal;
        fire && balance_select_pin;
      endsequence
      sequence s_take_plain;
        fire && !balance_select_pin;
      endsequence

      a_rd_range: assert property (
        ($signed(s_r.rd[g]) <= RD_MAX) && ($signed(s_r.rd[g]) >= RD_MIN))
        else $error("running disparity left its range");

      a_rd_update: assert property (
        s_take_bal |=> s_r.rd[g] == rd_next($past(s_r.rd[g]),
          s_r.lane[g].flag ? (DISP_ONE - $past(disp_w[g]))
                           : ($past(disp_w[g]) - DISP_ONE)))
        else $error("running disparity update wrong");

      // the largest step from zero lands exactly on the top limit
      a_rd_saturate: assert property (
        s_take_bal ##0 (s_r.rd[g] == RD_INIT) ##0 (disp_w[g] == RD_MIN)
        |=> s_r.rd[g] == RD_MAX)
        else $error("running disparity did not hold at its top");

      a_flag_data: assert property (
        s_take_bal |=> s_r.lane[g].data == (s_r.lane[g].flag
          ? ~$past(src_data[g*LANE_BITS +: LANE_BITS])
          : $past(src_data[g*LANE_BITS +: LANE_BITS])))
        else $error("balance bit does not match the sent data");

      a_zero_invert: assert property (
        s_take_bal ##0 (s_r.rd[g] == RD_INIT) |=> s_r.lane[g].flag)
        else $error("zero running disparity sent plain");

      a_pos_pos_inv: assert property (
        s_take_bal ##0 (s_r.rd[g] > RD_INIT) ##0 (disp_w[g] > 4'sh0) |=> s_r.lane[g].flag)
        else $error("positive pair not inverted");

      a_pos_neg_plain: assert property (
        s_take_bal ##0 (s_r.rd[g] > RD_INIT) ##0 (disp_w[g] <= 4'sh0) |=> !s_r.lane[g].flag)
        else $error("positive running, non-positive word not plain");

      a_neg_pos_plain: assert property (
        s_take_bal ##0 (s_r.rd[g] < RD_INIT) ##0 (disp_w[g] > 4'sh0) |=> !s_r.lane[g].flag)
        else $error("negative running, positive word not plain");

      a_neg_neg_inv: assert property (
        s_take_bal ##0 (s_r.rd[g] < RD_INIT) ##0 (disp_w[g] <= 4'sh0) |=> s_r.lane[g].flag)
        else $error("negative pair not inverted");

      a_plain_mode: assert property (
        s_take_plain |=> !s_r.lane[g].flag
          && (s_r.lane[g].data == $past(src_data[g*LANE_BITS +: LANE_BITS]))
          && $stable(s_r.rd[g]))
        else $error("unbalanced mode altered a lane");

      a_idle_hold: assert property (
        !fire |=> $stable(s_r.rd[g]) && $stable(s_r.lane[g]))
        else $error("lane changed without a taken word");
    end
  endgenerate

endmodule

// *** tb/ldc_ser_model.sv ***
// serializer and receiver model at the far end of the coded lanes
`timescale 1ns/1ns
module ldc_ser_model
  import ldc_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic stall_i,
  input wire ldc_lane_t [NUM_LANES-1:0] lane_word_i,
  output logic ser_ready_o,
  output logic [WORD_BITS-1:0] rx_word_o
);
  initial ser_ready_o = 1'b0;
  // random gaps stand for a serializer that is sometimes slow
  always @(posedge link_clk_i) begin
    ser_ready_o <= !stall_i && ($urandom_range(3) != 0);
  end
  always_comb begin
    for (int i = 0; i < NUM_LANES; i++) begin
      rx_word_o[LANE_BITS*i +: LANE_BITS] =
        lane_word_i[i].data ^ {LANE_BITS{lane_word_i[i].flag}};
    end
  end
endmodule

// *** tb/ldc_coder_tb_top.sv ***
// self-checking bench for the lane dc balance coder
`timescale 1ns/1ns
module ldc_coder_tb_top;
  import ldc_pkg::*;
  localparam int LW = NUM_LANES * (LANE_BITS + 1);
  logic sys_clk_i;
  logic link_clk_i;
  logic arst_n_i;
  logic tx_valid_i;
  logic bal_i;
  logic stall;
  logic tx_ready_o;
  logic ser_ready;
  logic lane_valid_o;
  logic calib_allowed_o;
  logic r;
  logic [WORD_BITS-1:0] tx_data_i;
  logic [WORD_BITS-1:0] rx_word;
  logic [WORD_BITS-1:0] w;
  ldc_lane_t [NUM_LANES-1:0] lane_word_o;
  logic [LW-1:0] exp_q[$];
  logic [WORD_BITS-1:0] raw_q[$];
  int rd_m[NUM_LANES];
  int error_cnt = 0;
  int n_tests = 0;
  int taken;

  ldc_coder dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .link_clk_i(link_clk_i),
    .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .balance_select_pin_i(bal_i), .ser_ready_i(ser_ready), .lane_word_o(lane_word_o),
    .lane_valid_o(lane_valid_o), .calib_allowed_o(calib_allowed_o));
  ldc_ser_model far_end (.link_clk_i(link_clk_i), .stall_i(stall),
    .lane_word_i(lane_word_o), .ser_ready_o(ser_ready), .rx_word_o(rx_word));

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // odd offset keeps the two clock edges from ever coinciding
  initial begin
    link_clk_i = 1'b0;
    #7;
    forever #15 link_clk_i = ~link_clk_i;
  end

  function automatic logic [LW-1:0] code(input logic [WORD_BITS-1:0] x, input logic b);
    logic [LW-1:0] o;
    logic [LANE_BITS-1:0] v;
    int d;
    int s;
    logic inv;
    for (int i = 0; i < NUM_LANES; i++) begin
      v = x[LANE_BITS*i +: LANE_BITS];
      d = 2 * $countones(v) - LANE_BITS;
      inv = b && (rd_m[i] == 0 || (rd_m[i] > 0) == (d > 0));
      o[7*i +: 7] = {inv, inv ? ~v : v};
      s = rd_m[i] + (inv ? 1 - d : d - 1);
      if (b) rd_m[i] = (s > 7) ? 7 : ((s < -6) ? -6 : s);
    end
    return o;
  endfunction

  function automatic logic [WORD_BITS-1:0] rnd();
    logic [63:0] t;
    t = {$urandom, $urandom};
    return t[WORD_BITS-1:0];
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic timeout();
    error_cnt++;
    $display("mismatch at %0t: wait ran out", $time);
    report_and_stop();
  endtask

  // called just after a rising edge; valid stays up so words go back to back
  task automatic send(input logic [WORD_BITS-1:0] x);
    int n;
    n = 0;
    tx_valid_i <= 1'b1;
    tx_data_i <= x;
    r = 1'b0;
    while (!r) begin
      @(negedge sys_clk_i);
      r = tx_ready_o;
      @(posedge sys_clk_i);
      n++;
      if (n > 2000) timeout();
    end
    exp_q.push_back(code(x, bal_i));
    raw_q.push_back(x);
  endtask

  task automatic burst(input int n);
    repeat (n) send(rnd());
  endtask

  task automatic drain();
    tx_valid_i <= 1'b0;
    for (int n = 0; exp_q.size() != 0; n++) begin
      if (n > 5000) timeout();
      @(posedge sys_clk_i);
    end
    repeat (10) @(posedge sys_clk_i);
  endtask

  task automatic set_mode(input logic b);
    bal_i <= b;
    repeat (8) @(posedge sys_clk_i);
    chk(calib_allowed_o, b);
  endtask

  task automatic do_reset();
    tx_valid_i <= 1'b0;
    arst_n_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    chk(tx_ready_o, 1'b1);
    chk(lane_valid_o, 1'b0);
    chk(calib_allowed_o, 1'b0);
    exp_q.delete();
    raw_q.delete();
    foreach (rd_m[i]) rd_m[i] = 0;
    arst_n_i <= 1'b1;
    @(posedge sys_clk_i);
  endtask

  // every coded word must match the oldest note, and restore to its source
  always @(negedge link_clk_i) begin
    if (arst_n_i === 1'b1 && lane_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(1, 0);
      end else begin
        chk(lane_word_o, exp_q.pop_front());
        chk(rx_word, raw_q.pop_front());
      end
    end
  end

  initial begin
    arst_n_i = 1'b0;
    tx_valid_i = 1'b0;
    tx_data_i = '0;
    bal_i = 1'b1;
    stall = 1'b0;
    taken = $urandom(58);
    do_reset();
    set_mode(1'b1);
    send('0);
    send('1);
    send({NUM_LANES{6'h07}});
    send({NUM_LANES{6'h01}});
    send({NUM_LANES{6'h3E}});
    burst(200);
    drain();
    // back-pressure: the far end stops taking until the buffer refuses
    stall <= 1'b1;
    repeat (4) @(posedge link_clk_i);
    @(posedge sys_clk_i);
    taken = 0;
    w = rnd();
    tx_data_i <= w;
    tx_valid_i <= 1'b1;
    repeat (45) begin
      @(negedge sys_clk_i);
      r = tx_ready_o;
      @(posedge sys_clk_i);
      if (r) begin
        exp_q.push_back(code(w, bal_i));
        raw_q.push_back(w);
        taken++;
        w = rnd();
        tx_data_i <= w;
      end
    end
    tx_valid_i <= 1'b0;
    chk(taken >= FIFO_DEPTH, 1'b1);
    chk(tx_ready_o, 1'b0);
    stall <= 1'b0;
    drain();
    set_mode(1'b0);
    burst(60);
    drain();
    set_mode(1'b1);
    burst(60);
    burst(20);
    do_reset();
    set_mode(1'b1);
    burst(40);
    drain();
    report_and_stop();
  end
endmodule
